// File: stf_dma_model.sv
// Purpose: dma controller model facing the framer handshake
// Assumes: every byte is 8'h01, one byte per read strobe
// Notes: released data bus shows the inverse of the last byte
`timescale 1ns/1ns
module stf_dma_model
(
	// clock and reset
	input  wire logic       ref_clk_i,
	input  wire logic       reset_n_i,
	// framer side
	input  wire logic       transmit_request_i,
	input  wire logic       byte_ready_i,
	output logic            handshake_clock_o,
	output logic            mem_read_strobe_n_o,
	output logic            end_of_process_n_o,
	output logic [7:0]      dma_data_o,
	// bench control
	input  wire logic       slow_i,
	input  wire logic [7:0] n_bytes_i,
	output logic [7:0]      n_taken_o
);
	logic [1:0] hs_div_r;
	logic [1:0] step_r;
	logic [3:0] hold_r;
	logic       req_r;
	logic       dma_address_enable_r;

	assign handshake_clock_o = hs_div_r[1];

	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			hs_div_r <= 2'h0;
			step_r <= 2'h0;
			hold_r <= 4'h0;
			req_r <= 1'b0;
			dma_address_enable_r <= 1'b0;
			mem_read_strobe_n_o <= 1'b1;
			end_of_process_n_o <= 1'b1;
			dma_data_o <= 8'h00;
			n_taken_o <= 8'h00;
		end
		else
		begin
			hs_div_r <= hs_div_r + 2'h1;
			req_r <= transmit_request_i;
			dma_address_enable_r <= transmit_request_i;
			if (transmit_request_i && !req_r)
				n_taken_o <= 8'h00;
			if (!transmit_request_i)
				end_of_process_n_o <= 1'b1;
			if (hold_r != 4'h0)
				hold_r <= hold_r - 4'h1;
			else
				case (step_r)
				2'h0: if (transmit_request_i && byte_ready_i && n_taken_o != n_bytes_i)
				begin
					dma_data_o <= 8'h01;
					mem_read_strobe_n_o <= 1'b0;
					// fast strobe must land before the next load edge, ten cycles after transfer
					hold_r <= slow_i ? 4'h8 : 4'h1;
					step_r <= 2'h1;
				end
				2'h1:
				begin
					mem_read_strobe_n_o <= 1'b1;
					n_taken_o <= n_taken_o + 8'h1;
					end_of_process_n_o <= (n_taken_o + 8'h1) != n_bytes_i;
					hold_r <= 4'h5;
					step_r <= 2'h2;
				end
				2'h2:
				begin
					dma_data_o <= ~dma_data_o;
					step_r <= 2'h3;
				end
				// no new strobe until ready has dropped
				default: if (!byte_ready_i)
					step_r <= 2'h0;
				endcase
		end
	end
endmodule

// File: stf_framer.sv
// Purpose: transmit start-up, preamble, data serialiser and check-sequence framing
// Assumes: dma and line pins asynchronous to ref_clk_i, host port on the same clock; bit rate made by fractional tick
// Notes: bit ticks jitter by one reference cycle, average is exact
`timescale 1ns/1ns
module stf_framer
(
	// clock and reset
	input  wire logic             ref_clk_i,
	input  wire logic             reset_n_i,
	// host port write, same clock
	input  wire logic             io_wr_i,
	input  wire logic [7:0]       io_addr_i,
	// dma side pins
	input  wire logic             end_of_process_n_i,
	input  wire logic             mem_read_strobe_n_i,
	input  wire logic             handshake_clock_i,
	input  wire logic [7:0]       dma_data_i,
	// line receive pin for carrier
	input  wire logic             rx_line_i,
	// dma handshake outputs
	output logic                  transmit_request_o,
	output logic                  byte_ready_o,
	output logic                  byte_transfer_n_o,
	output logic                  transmit_done_n_o,
	output logic                  transmit_start_cmd_o,
	// serial side
	output logic                  byte_clk_o,
	output logic                  byte_clk_n_o,
	output logic                  tx_data_o,
	output stf_pkg::stf_sel_t     tx_sel_o,
	output logic                  crc_preset_n_o,
	output logic                  line_enable_o,
	output logic                  line_status_o,
	output logic                  carrier_sense_o
);
	import stf_pkg::*;

	logic [11:0] sync1_r;
	logic [11:0] sync2_r;
	logic [11:0] sync3_r;
	logic [14:0] acc_r;
	logic [14:0] acc_sum;
	logic        tick;
	logic [2:0]  bph_r;
	logic        inv_edge;
	logic        byte_edge;
	logic [3:0]  cs_cnt_r;
	logic        rx_toggle;
	logic        cs;
	logic [6:0]  gdiv_r;
	logic [1:0]  gap_cnt_r;
	logic        gap_ok;
	logic        gap_pulse;
	logic        start_cmd_r;
	logic        start_wr;
	stf_state_t  st_r;
	stf_state_t  st_nxt;
	logic [6:0]  fbit_r;
	logic [6:0]  pre_idx;
	logic        pre_done_r;
	logic        preset_r;
	logic        load_pulse;
	logic        xfer_pulse;
	logic        xfer_n_r;
	logic        xfer_pend_r;
	logic        rdy_r;
	logic        strobe_rise;
	logic        hs_rise;
	logic [7:0]  hold_r;
	logic [7:0]  shift_r;
	logic        load_now;
	logic        data_bit;
	logic        pre_bit;
	logic [31:0] crc_r;
	logic [31:0] crc_step;
	logic        eop_seen_r;
	logic [1:0]  eop_cnt_r;
	logic [1:0]  fcs_cnt_r;
	logic        done_n_r;
	logic        line_en_r;
	logic        out_r;
	stf_sel_t    sel_r;
	stf_sel_t    sel_nxt;
	logic        out_nxt;
	logic        eop_low;

	// pins: two flops, third only for edge detection off the second
	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			sync1_r <= SYNC_RST;
			sync2_r <= SYNC_RST;
			sync3_r <= SYNC_RST;
		end
		else
		begin
			sync1_r <= {rx_line_i, end_of_process_n_i, mem_read_strobe_n_i, handshake_clock_i, dma_data_i};
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
		end
	end

	assign rx_toggle   = sync2_r[11] ^ sync3_r[11];
	assign eop_low     = !sync2_r[10];
	assign strobe_rise = sync2_r[9] && !sync3_r[9];
	assign hs_rise     = sync2_r[8] && !sync3_r[8];

	// fractional bit tick, 10 MHz average
	assign acc_sum   = acc_r + 15'(BIT_CLK_KHZ);
	assign tick      = acc_sum >= 15'(REF_CLK_KHZ);
	assign inv_edge  = tick && (bph_r == 3'h7);
	assign byte_edge = tick && (bph_r == 3'h3);

	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			acc_r <= 15'h0;
			bph_r <= 3'h0;
		end
		else
		begin
			acc_r <= tick ? acc_sum - 15'(REF_CLK_KHZ) : acc_sum;
			bph_r <= tick ? bph_r + 3'h1 : bph_r;
		end
	end

	assign byte_clk_o   = bph_r[2];
	assign byte_clk_n_o = !bph_r[2];

	// carrier one-shot, retriggered per transition
	assign cs = cs_cnt_r != 4'h0;
	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			cs_cnt_r <= 4'h0;
		else if (rx_toggle)
			cs_cnt_r <= 4'(CS_HOLD_CYC);
		else if (cs)
			cs_cnt_r <= cs_cnt_r - 4'h1;
	end

	// gap timer, cleared during carrier
	assign gap_pulse = gdiv_r == 7'(GAP_PULSE_CYC - 1);
	assign gap_ok    = gap_cnt_r == GAP_PULSES;
	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			gdiv_r    <= 7'h0;
			gap_cnt_r <= 2'h0;
		end
		else
		begin
			gdiv_r <= (gap_pulse || cs) ? 7'h0 : gdiv_r + 7'h1;
			if (cs)
				gap_cnt_r <= 2'h0;
			else if (gap_pulse && !gap_ok)
				gap_cnt_r <= gap_cnt_r + 2'h1;
		end
	end

	// start command; a write in the done cycle still sets it
	assign start_wr = io_wr_i && (io_addr_i == START_PORT);
	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			start_cmd_r <= 1'b0;
		else if (start_wr)
			start_cmd_r <= 1'b1;
		else if (!done_n_r)
			start_cmd_r <= 1'b0;
	end

	// framing sequencer
	always_comb
	begin
		st_nxt = st_r;
		case (st_r)
			ST_IDLE:
				if (inv_edge && start_cmd_r && gap_ok)
					st_nxt = ST_PRE;
			ST_PRE:
				if (inv_edge && fbit_r == PRE_LAST_BIT - 7'h1)
					st_nxt = ST_DATA;
			ST_DATA:
				if (inv_edge && eop_seen_r && eop_cnt_r == EOP_TO_FCS)
					st_nxt = ST_FCS;
			ST_FCS:
				if (inv_edge && fcs_cnt_r == FCS_EDGES)
					st_nxt = ST_IDLE;
			default:
				st_nxt = ST_IDLE;
		endcase
	end

	assign load_pulse = byte_edge && (st_r == ST_PRE) && pre_done_r;
	assign xfer_pulse = load_pulse || (byte_edge && st_r == ST_DATA && !eop_seen_r);
	assign load_now   = inv_edge && (st_nxt == ST_DATA);
	assign data_bit   = load_now ? hold_r[0] : shift_r[0];
	// index of the bit going out at this tick; fbit_r holds the previous one
	assign pre_idx    = (st_r == ST_PRE) ? fbit_r + 7'h1 : 7'h0;
	assign pre_bit    = (preset_r && pre_idx >= PRE_ONES_BIT) ? 1'b1 : !pre_idx[0];
	assign crc_step   = (crc_r >> 1) ^ ((crc_r[0] ^ data_bit) ? CRC_POLY : 32'h0);

	// selector; idle falls back to the zero input
	always_comb
	begin
		case (st_nxt)
			ST_PRE:  sel_nxt = SEL_PRE;
			ST_DATA: sel_nxt = SEL_DATA;
			ST_FCS:  sel_nxt = SEL_FCS;
			default: sel_nxt = SEL_ZERO;
		endcase
		case (sel_nxt)
			SEL_PRE:  out_nxt = pre_bit;
			SEL_DATA: out_nxt = data_bit;
			SEL_FCS:  out_nxt = !crc_r[0];
			default:  out_nxt = 1'b0;
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			st_r       <= ST_IDLE;
			fbit_r     <= 7'h0;
			pre_done_r <= 1'b0;
			preset_r   <= 1'b0;
			sel_r      <= SEL_ZERO;
			out_r      <= 1'b0;
			shift_r    <= 8'h0;
			crc_r      <= CRC_PRESET;
			line_en_r  <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt;
			if (tick)
			begin
				sel_r     <= sel_nxt;
				out_r     <= out_nxt;
				line_en_r <= st_nxt != ST_IDLE;
				fbit_r    <= (st_nxt == ST_PRE) ? pre_idx : 7'h0;
				shift_r   <= load_now ? {1'b0, hold_r[7:1]} : {1'b0, shift_r[7:1]};
				if (st_nxt == ST_DATA)
					crc_r <= crc_step;
				else if (st_nxt == ST_FCS)
					crc_r <= {1'b1, crc_r[31:1]};
				else
					crc_r <= CRC_PRESET;
			end
			if (st_r != ST_PRE)
				pre_done_r <= 1'b0;
			else if (tick && fbit_r == PRE_DONE_BIT - 7'h1)
				pre_done_r <= 1'b1;
			if (st_r != ST_PRE)
				preset_r <= 1'b0;
			else if (load_pulse)
				preset_r <= 1'b1;
		end
	end

	// end of process and shutdown counting on inverted byte clock
	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			eop_seen_r <= 1'b0;
			eop_cnt_r  <= 2'h0;
			fcs_cnt_r  <= 2'h0;
			done_n_r   <= 1'b1;
		end
		else
		begin
			done_n_r <= !(st_r == ST_FCS && st_nxt == ST_IDLE);
			if (st_r == ST_IDLE)
			begin
				eop_seen_r <= 1'b0;
				eop_cnt_r  <= 2'h0;
			end
			else
			begin
				if (eop_low)
					eop_seen_r <= 1'b1;
				if (inv_edge && eop_seen_r && st_r == ST_DATA)
					eop_cnt_r <= eop_cnt_r + 2'h1;
			end
			if (st_r != ST_FCS)
				fcs_cnt_r <= 2'h0;
			else if (inv_edge)
				fcs_cnt_r <= fcs_cnt_r + 2'h1;
		end
	end

	// byte ready handshake; a transfer in the strobe cycle is not lost
	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			xfer_n_r    <= 1'b1;
			xfer_pend_r <= 1'b0;
			rdy_r       <= 1'b0;
			hold_r      <= 8'h0;
		end
		else
		begin
			xfer_n_r <= !xfer_pulse;
			if (xfer_pulse)
				xfer_pend_r <= 1'b1;
			else if (strobe_rise)
				xfer_pend_r <= 1'b0;
			if (hs_rise)
				rdy_r <= xfer_pend_r;
			if (strobe_rise && rdy_r)
				hold_r <= sync2_r[7:0];
		end
	end

	assign transmit_request_o   = st_r != ST_IDLE;
	assign byte_ready_o         = rdy_r;
	assign byte_transfer_n_o    = xfer_n_r;
	assign transmit_done_n_o    = done_n_r;
	assign transmit_start_cmd_o = start_cmd_r;
	assign tx_data_o            = out_r;
	assign tx_sel_o             = sel_r;
	assign crc_preset_n_o       = sel_r == SEL_DATA || sel_r == SEL_FCS;
	assign line_enable_o        = line_en_r;
	assign line_status_o        = line_en_r;
	assign carrier_sense_o      = cs;

	gap_clear_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) cs |=> gap_cnt_r == 2'h0)
		else $error("gap count not held clear during carrier");
	start_cond_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		$rose(transmit_request_o) |-> $past(gap_ok) && $past(start_cmd_r) && $past(inv_edge))
		else $error("request set without start, gap or inverted edge");
	line_follow_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		$rose(transmit_request_o) |-> ##[0:6] line_enable_o && line_status_o)
		else $error("line enable late");
	byte_comp_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) byte_clk_o != byte_clk_n_o)
		else $error("byte clocks not complementary");
	zero_sel_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) tx_sel_o == SEL_ZERO |-> !tx_data_o)
		else $error("shutdown input not zero");
	pre_count_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) $rose(pre_done_r) |-> fbit_r == PRE_DONE_BIT)
		else $error("preamble count wrong");
	xfer_pulse_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		$fell(byte_transfer_n_o) |=> byte_transfer_n_o)
		else $error("transfer pulse longer than one cycle");
	ready_drop_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		strobe_rise && !xfer_pulse ##1 hs_rise |=> !byte_ready_o)
		else $error("byte ready not dropped after strobe");
	done_clear_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		!transmit_done_n_o && !start_wr |=> !transmit_start_cmd_o)
		else $error("done did not clear start");
	shut_count_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		st_r == ST_FCS && st_nxt == ST_IDLE |-> fcs_cnt_r == FCS_EDGES && inv_edge)
		else $error("shutdown not on fourth edge");
	frame_start_c: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i) $rose(transmit_request_o));
	data_phase_c: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i) $rose(tx_sel_o == SEL_DATA));
	frame_done_c: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i) $fell(transmit_done_n_o));
endmodule

// File: stf_framer_bench.sv
// Purpose: self-checking bench for the transmit framer
// Assumes: dma model answers every byte request
// Notes: bit ticks jitter one cycle, so bit-time checks allow one cycle; the gap check allows 238 to 262
`timescale 1ns/1ns
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
	$display("MISMATCH t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module stf_framer_bench;
	import stf_pkg::*;
	logic       ref_clk_i, reset_n_i, io_wr_i, end_of_process_n_i, mem_read_strobe_n_i;
	logic       handshake_clock_i, rx_line_i, transmit_request_o, byte_ready_o, byte_transfer_n_o;
	logic       transmit_done_n_o, transmit_start_cmd_o, byte_clk_o, byte_clk_n_o, tx_data_o;
	logic       crc_preset_n_o, line_enable_o, line_status_o, carrier_sense_o, slow;
	logic [7:0] io_addr_i, dma_data_i, n_bytes, n_taken;
	stf_sel_t   tx_sel_o;
	int         n_mismatch;
	int         n_tests;

	stf_framer DUT (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .io_wr_i(io_wr_i), .io_addr_i(io_addr_i),
		.end_of_process_n_i(end_of_process_n_i), .mem_read_strobe_n_i(mem_read_strobe_n_i),
		.handshake_clock_i(handshake_clock_i), .dma_data_i(dma_data_i), .rx_line_i(rx_line_i),
		.transmit_request_o(transmit_request_o), .byte_ready_o(byte_ready_o),
		.byte_transfer_n_o(byte_transfer_n_o), .transmit_done_n_o(transmit_done_n_o),
		.transmit_start_cmd_o(transmit_start_cmd_o), .byte_clk_o(byte_clk_o), .byte_clk_n_o(byte_clk_n_o),
		.tx_data_o(tx_data_o), .tx_sel_o(tx_sel_o), .crc_preset_n_o(crc_preset_n_o),
		.line_enable_o(line_enable_o), .line_status_o(line_status_o), .carrier_sense_o(carrier_sense_o));

	stf_dma_model PEER (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .transmit_request_i(transmit_request_o),
		.byte_ready_i(byte_ready_o), .handshake_clock_o(handshake_clock_i),
		.mem_read_strobe_n_o(mem_read_strobe_n_i), .end_of_process_n_o(end_of_process_n_i),
		.dma_data_o(dma_data_i), .slow_i(slow), .n_bytes_i(n_bytes), .n_taken_o(n_taken));

	initial
	begin
		ref_clk_i = 1'b0;
		forever #20 ref_clk_i = ~ref_clk_i;
	end

	task print_verdict;
	begin
		if (n_mismatch == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	end
	endtask

	task host_wr(input logic [7:0] a);
	begin
		@(posedge ref_clk_i);
		io_wr_i <= 1'b1;
		io_addr_i <= a;
		@(posedge ref_clk_i);
		io_wr_i <= 1'b0;
		#1;
	end
	endtask

	task automatic t_idle;
		int r0 = -1;
		int r1 = -1;
		logic prev = 1'b1;
	begin
		host_wr(8'h01);
		`CHK(transmit_start_cmd_o, 1'b0)
		for (int i = 0; i < 60; i++)
		begin
			@(posedge ref_clk_i);
			#1;
			if (byte_clk_o && !prev && r0 >= 0 && r1 < 0)
				r1 = i;
			if (byte_clk_o && !prev && r0 < 0)
				r0 = i;
			prev = byte_clk_o;
		end
		`CHK((r1 - r0) inside {[19:21]}, 1'b1)
	end
	endtask

	// carrier first makes the gap timer restart from the carrier drop
	task automatic t_frame(input logic carr, input logic slw, input logic [7:0] nb);
		int t_rq = -1;
		int t_d = -1;
		int t_f = -1;
		int t_end = -1;
		int t_cs = -1;
		int pre_r = 0;
		int xf = 0;
		int bad = 0;
		int dn = 0;
		int en = 0;
		logic first = 1'b0;
		logic prev = 1'b0;
	begin
		slow <= slw;
		n_bytes <= nb;
		if (carr)
		begin
			for (int i = 0; i < 24; i++)
			begin
				repeat (3) @(posedge ref_clk_i);
				rx_line_i <= ~rx_line_i;
				if (i == 12)
					host_wr(8'h00);
				if (i == 12)
					`CHK(carrier_sense_o, 1'b1)
			end
			#1;
			`CHK(transmit_request_o, 1'b0)
		end
		else
			host_wr(8'h00);
		`CHK(transmit_start_cmd_o, 1'b1)
		for (int t = 0; t < 3000 && (t_end < 0 || t < t_end + 4); t++)
		begin
			@(posedge ref_clk_i);
			#1;
			if (carrier_sense_o)
				t_cs = t;
			if (transmit_request_o && t_rq < 0)
				t_rq = t;
			if (tx_sel_o === SEL_DATA && t_d < 0)
			begin
				t_d = t;
				first = tx_data_o;
				bad += (crc_preset_n_o !== 1'b1);
			end
			if (tx_sel_o === SEL_FCS && t_f < 0)
				t_f = t;
			if (transmit_request_o && tx_sel_o === SEL_PRE)
			begin
				pre_r += (tx_data_o && !prev);
				xf += (byte_transfer_n_o === 1'b0);
				bad += (crc_preset_n_o !== 1'b0);
			end
			bad += (line_status_o !== line_enable_o) || (byte_clk_n_o !== ~byte_clk_o);
			en += (line_enable_o === 1'b1);
			dn += (transmit_done_n_o === 1'b0);
			if (t_rq >= 0 && !transmit_request_o && t_end < 0)
				t_end = t;
			prev = tx_data_o;
		end
		if (carr)
			`CHK((t_rq - t_cs) inside {[238:262]}, 1'b1)
		`CHK((t_d - t_rq) inside {[159:161]}, 1'b1)
		`CHK(pre_r, 32)
		`CHK(xf, 1)
		`CHK(first, 1'b1)
		`CHK((t_end - t_f) inside {[79:81]}, 1'b1)
		`CHK(bad, 0)
		`CHK(en > 0, 1'b1)
		`CHK(dn, 1)
		`CHK(transmit_start_cmd_o, 1'b0)
		`CHK(tx_sel_o, SEL_ZERO)
		`CHK(tx_data_o, 1'b0)
		`CHK(n_taken, nb)
	end
	endtask

	initial
	begin
		repeat (20000) @(posedge ref_clk_i);
		n_mismatch++;
		print_verdict;
	end

	initial
	begin
		n_mismatch = 0;
		n_tests = 0;
		reset_n_i = 1'b0;
		io_wr_i = 1'b0;
		io_addr_i = 8'h00;
		rx_line_i = 1'b0;
		slow = 1'b0;
		n_bytes = 8'h00;
		repeat (19) @(posedge ref_clk_i);
		#1;
		`CHK(transmit_done_n_o, 1'b1)
		`CHK(tx_sel_o, SEL_ZERO)
		@(posedge ref_clk_i);
		reset_n_i <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		t_idle;
		t_frame(1'b1, 1'b0, 8'h03);
		t_frame(1'b0, 1'b1, 8'h01);
		print_verdict;
	end
endmodule

// File: stf_pkg.sv
// Purpose: constants for the serial transmit framer
// Assumes: 25 MHz reference clock, 10 Mb/s line rate
package stf_pkg;
	localparam int unsigned REF_CLK_KHZ  = 25000;
	localparam int unsigned BIT_CLK_KHZ  = 10000;
	localparam int unsigned GAP_PULSE_NS = 3200;
	localparam int unsigned GAP_PULSE_CYC = (GAP_PULSE_NS * REF_CLK_KHZ) / 1000000;
	localparam int unsigned CS_HOLD_NS   = 300;
	localparam int unsigned CS_HOLD_CYC  = (CS_HOLD_NS * REF_CLK_KHZ + 999999) / 1000000;
	localparam logic [7:0]  START_PORT   = 8'h00;
	localparam logic [1:0]  GAP_PULSES   = 2'h3;
	localparam logic [6:0]  PRE_DONE_BIT = 7'h38;
	localparam logic [6:0]  PRE_ONES_BIT = 7'h3e;
	localparam logic [6:0]  PRE_LAST_BIT = 7'h40;
	localparam logic [1:0]  EOP_TO_FCS   = 2'h1;
	localparam logic [1:0]  FCS_EDGES    = 2'h3;
	localparam logic [31:0] CRC_POLY     = 32'hedb88320;
	localparam logic [31:0] CRC_PRESET   = 32'hffffffff;
	localparam logic [11:0] SYNC_RST     = 12'h600;
	typedef enum logic [1:0] {SEL_PRE = 2'h0, SEL_DATA = 2'h1, SEL_ZERO = 2'h2, SEL_FCS = 2'h3} stf_sel_t;
	typedef enum {ST_IDLE, ST_PRE, ST_DATA, ST_FCS} stf_state_t;
endpackage
